/* src/cip_pkg.sv */
`default_nettype none
package cip_pkg;
    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] CIP_OFS_INSTR = 8'h00;
    localparam logic [7:0] CIP_OFS_BASE = 8'h04;
    localparam logic [7:0] CIP_OFS_PC = 8'h08;
    localparam logic [7:0] CIP_OFS_FLAGS = 8'h0C;
    localparam logic [7:0] CIP_OFS_STATUS = 8'h10;
    localparam logic [7:0] CIP_OFS_ADDR = 8'h14;
    localparam logic [7:0] CIP_OFS_COUNT = 8'h18;
    // ************************************************************
    // instruction field positions
    // ************************************************************
    localparam int CIP_BIT_COND = 28;
    localparam int CIP_BIT_PRE = 24;
    localparam int CIP_BIT_UP = 23;
    localparam int CIP_BIT_LEN = 22;
    localparam int CIP_BIT_WB = 21;
    localparam int CIP_BIT_LOAD = 20;
    localparam int CIP_BIT_BASE = 16;
    localparam int CIP_BIT_NUM = 8;
    localparam int CIP_BIT_OPTYPE = 4;
    localparam logic [3:0] CIP_CLASS_CDP = 4'hE;
    localparam logic [2:0] CIP_CLASS_XFER = 3'h6;
    localparam logic [3:0] CIP_PC_INDEX = 4'hF;
    // ************************************************************
    // arithmetic and reset values
    // ************************************************************
    localparam logic [31:0] CIP_PC_AHEAD = 32'h0000_0008;
    localparam logic [31:0] CIP_WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] CIP_RST_WORD = 32'h0000_0000;
    localparam logic [3:0] CIP_RST_FLAGS = 4'h0;
    // ************************************************************
    // status bit positions
    // ************************************************************
    localparam int CIP_ST_BUSY = 0;
    localparam int CIP_ST_DONE = 1;
    localparam int CIP_ST_SKIP = 2;
    localparam int CIP_ST_UNDEF = 3;
    localparam int CIP_ST_ABORT = 4;
    localparam int CIP_ST_WB = 5;
endpackage : cip_pkg
`default_nettype wire

/* src/cip_if.sv */
`timescale 1ns/1ps
`default_nettype none
// shared coprocessor handshake and data lines
interface cip_if;
    logic offer;
    logic [31:0] instr;
    logic absent;
    logic busy;
    logic word_strobe;
    logic [31:0] store_data;
    logic last_word;
    logic load_valid;
    logic [31:0] load_data;
    logic xfer_abort;
    modport core_end (output offer, instr, word_strobe, load_valid, load_data, xfer_abort,
                      input absent, busy, store_data, last_word);
    modport coproc_end (input offer, instr, word_strobe, load_valid, load_data, xfer_abort,
                        output absent, busy, store_data, last_word);
endinterface : cip_if
`default_nettype wire

/* src/cip_core_end.sv */
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cip_core_end
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // memory port, answers in the cycle of the request
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_abort,
    // trap pulses
    output logic trap_undef,
    output logic trap_abort,
    // coprocessor side
    cip_if.core_end cp
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_OFFER = 5'h02,
        ST_WAIT = 5'h04,
        ST_ISSUE = 5'h08,
        ST_RESP = 5'h10
    } cip_core_state_t;

    // ************************************************************
    // helpers
    // ************************************************************
    // condition test on nzcv
    function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
        logic n;
        logic z;
        logic cy;
        logic v;
        n = f[3];
        z = f[2];
        cy = f[1];
        v = f[0];
        case (c)
            4'h0: cond_pass = z;
            4'h1: cond_pass = !z;
            4'h2: cond_pass = cy;
            4'h3: cond_pass = !cy;
            4'h4: cond_pass = n;
            4'h5: cond_pass = !n;
            4'h6: cond_pass = v;
            4'h7: cond_pass = !v;
            4'h8: cond_pass = cy && !z;
            4'h9: cond_pass = !cy || z;
            4'hA: cond_pass = (n == v);
            4'hB: cond_pass = (n != v);
            4'hC: cond_pass = !z && (n == v);
            4'hD: cond_pass = z || (n != v);
            4'hE: cond_pass = 1'b1;
            default: cond_pass = 1'b0;
        endcase
    endfunction : cond_pass

    // byte-lane merge for wishbone writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        lane_merge = r;
    endfunction : lane_merge

    // ************************************************************
    // state
    // ************************************************************
    cip_core_state_t state_reg;
    logic [31:0] instr_reg;
    logic [31:0] base_reg;
    logic [31:0] pc_reg;
    logic [3:0] flags_reg;
    logic [5:0] status_reg;
    logic [31:0] addr_reg;
    logic [31:0] modified_reg;
    logic [15:0] busy_cnt_reg;
    logic [15:0] word_cnt_reg;
    logic last_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic offer_seen_reg;

    logic wb_take;
    logic start;
    logic [3:0] base_idx;
    logic [31:0] base_eff;
    logic [31:0] offset;
    logic [31:0] modified;
    logic wb_wanted;
    logic accepted;
    logic refused;

    assign wb_take = wb_cyc_i && wb_stb_i && ack_reg;
    assign start = wb_take && wb_we_i && (wb_adr_i == cip_pkg::CIP_OFS_INSTR)
                   && (state_reg == ST_IDLE);
    assign base_idx = instr_reg[cip_pkg::CIP_BIT_BASE +: 4];
    // pc base sees the pipeline ahead
    assign base_eff = (base_idx == cip_pkg::CIP_PC_INDEX) ? pc_reg + cip_pkg::CIP_PC_AHEAD
                                                          : base_reg;
    assign offset = {22'h000000, instr_reg[7:0], 2'h0}; // word offset as bytes
    assign modified = instr_reg[cip_pkg::CIP_BIT_UP] ? base_eff + offset
                                                     : base_eff - offset;
    // no implicit write-back when post-indexed; pc never written back
    assign wb_wanted = instr_reg[cip_pkg::CIP_BIT_WB] && (base_idx != cip_pkg::CIP_PC_INDEX);
    assign accepted = !cp.absent && !cp.busy;
    assign refused = cp.absent && cp.busy;

    // ************************************************************
    // wishbone slave: ack one cycle after request, data with it
    // ************************************************************
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_reg <= 1'b0;
            dat_reg <= cip_pkg::CIP_RST_WORD;
        end
        else
        begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
            case (wb_adr_i)
                cip_pkg::CIP_OFS_INSTR: dat_reg <= instr_reg;
                cip_pkg::CIP_OFS_BASE: dat_reg <= base_reg;
                cip_pkg::CIP_OFS_PC: dat_reg <= pc_reg;
                cip_pkg::CIP_OFS_FLAGS: dat_reg <= {28'h0000000, flags_reg};
                cip_pkg::CIP_OFS_STATUS: dat_reg <= {26'h0000000, status_reg};
                cip_pkg::CIP_OFS_ADDR: dat_reg <= addr_reg;
                cip_pkg::CIP_OFS_COUNT: dat_reg <= {busy_cnt_reg, word_cnt_reg};
                default: dat_reg <= cip_pkg::CIP_RST_WORD; // unmapped reads zero
            endcase
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // software-owned registers; base also takes write-back
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            instr_reg <= cip_pkg::CIP_RST_WORD;
            base_reg <= cip_pkg::CIP_RST_WORD;
            pc_reg <= cip_pkg::CIP_RST_WORD;
            flags_reg <= cip_pkg::CIP_RST_FLAGS;
        end
        else
        begin
            if (start)
                instr_reg <= lane_merge(instr_reg, wb_dat_i, wb_sel_i);
            if (wb_take && wb_we_i && state_reg == ST_IDLE)
            begin
                if (wb_adr_i == cip_pkg::CIP_OFS_PC)
                    pc_reg <= lane_merge(pc_reg, wb_dat_i, wb_sel_i);
                if (wb_adr_i == cip_pkg::CIP_OFS_FLAGS)
                    flags_reg <= 4'(lane_merge({28'h0000000, flags_reg}, wb_dat_i, wb_sel_i));
                if (wb_adr_i == cip_pkg::CIP_OFS_BASE)
                    base_reg <= lane_merge(base_reg, wb_dat_i, wb_sel_i);
            end
            // write-back at end of transfer, aborted or not
            if (state_reg == ST_RESP && (mem_abort || last_reg) && wb_wanted)
                base_reg <= modified_reg;
        end
    end

    // ************************************************************
    // instruction sequencer
    // ************************************************************
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= ST_IDLE;
            status_reg <= 6'h00;
            addr_reg <= cip_pkg::CIP_RST_WORD;
            modified_reg <= cip_pkg::CIP_RST_WORD;
            busy_cnt_reg <= 16'h0000;
            word_cnt_reg <= 16'h0000;
            last_reg <= 1'b0;
            trap_undef <= 1'b0;
            trap_abort <= 1'b0;
            cp.offer <= 1'b0;
            offer_seen_reg <= 1'b0;
        end
        else
        begin
            trap_undef <= 1'b0;
            trap_abort <= 1'b0;
            // offer as it stood one edge ago: the answer lags the offer by one edge
            offer_seen_reg <= cp.offer;
            case (state_reg)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        status_reg <= 6'h01;
                        busy_cnt_reg <= 16'h0000;
                        word_cnt_reg <= 16'h0000;
                        state_reg <= ST_OFFER;
                    end
                end
                ST_OFFER:
                begin
                    // failed condition: not executed, nothing offered
                    if (!cond_pass(instr_reg[cip_pkg::CIP_BIT_COND +: 4], flags_reg))
                    begin
                        status_reg <= 6'h06;
                        state_reg <= ST_IDLE;
                    end
                    else
                    begin
                        cp.offer <= 1'b1;
                        modified_reg <= modified;
                        addr_reg <= instr_reg[cip_pkg::CIP_BIT_PRE] ? modified
                                                                    : base_eff;
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    // first offered edge still shows the idle refusal, so it is skipped
                    if (offer_seen_reg && refused)
                    begin
                        cp.offer <= 1'b0;
                        trap_undef <= 1'b1;
                        status_reg <= 6'h0A;
                        state_reg <= ST_IDLE;
                    end
                    else if (offer_seen_reg && accepted)
                    begin
                        cp.offer <= 1'b0;
                        // only bit 4 and bits 24-27 steer the class
                        if (instr_reg[27:24] == cip_pkg::CIP_CLASS_CDP
                            && !instr_reg[cip_pkg::CIP_BIT_OPTYPE])
                        begin
                            status_reg <= 6'h02; // no wait for the operation
                            state_reg <= ST_IDLE;
                        end
                        else
                            state_reg <= ST_ISSUE;
                    end
                    else if (offer_seen_reg && cp.busy)
                        busy_cnt_reg <= busy_cnt_reg + 16'h0001; // b cycles
                end
                ST_ISSUE:
                begin
                    // coprocessor data and length are sampled here
                    last_reg <= cp.last_word;
                    word_cnt_reg <= word_cnt_reg + 16'h0001;
                    state_reg <= ST_RESP;
                end
                ST_RESP:
                begin
                    if (mem_abort)
                    begin
                        trap_abort <= 1'b1;
                        status_reg <= {wb_wanted, 5'h12};
                        state_reg <= ST_IDLE;
                    end
                    else if (last_reg)
                    begin
                        status_reg <= {wb_wanted, 5'h02};
                        state_reg <= ST_IDLE;
                    end
                    else
                    begin
                        addr_reg <= addr_reg + cip_pkg::CIP_WORD_STEP;
                        state_reg <= ST_ISSUE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // memory and word strobes
    // ************************************************************
    // full address incl. low bits goes out untouched
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= cip_pkg::CIP_RST_WORD;
            mem_wdata <= cip_pkg::CIP_RST_WORD;
            cp.word_strobe <= 1'b0;
            cp.load_valid <= 1'b0;
            cp.load_data <= cip_pkg::CIP_RST_WORD;
            cp.xfer_abort <= 1'b0;
        end
        else
        begin
            mem_req <= (state_reg == ST_ISSUE);
            cp.word_strobe <= (state_reg == ST_ISSUE);
            cp.load_valid <= (state_reg == ST_RESP) && !mem_abort && mem_we_load();
            cp.xfer_abort <= (state_reg == ST_RESP) && mem_abort;
            if (state_reg == ST_ISSUE)
            begin
                mem_we <= !instr_reg[cip_pkg::CIP_BIT_LOAD];
                mem_addr <= addr_reg;
                mem_wdata <= cp.store_data;
            end
            if (state_reg == ST_RESP)
                cp.load_data <= mem_rdata;
        end
    end

    // load direction of the held instruction
    function automatic logic mem_we_load();
        mem_we_load = instr_reg[cip_pkg::CIP_BIT_LOAD];
    endfunction : mem_we_load

    assign cp.instr = instr_reg;
endmodule : cip_core_end
`default_nettype wire

/* src/cip_coproc_end.sv */
`timescale 1ns/1ps
`default_nettype none
module cip_coproc_end
#(
    parameter logic [3:0] CP_NUM = 4'h1,
    parameter int SHORT_LEN = 1,
    parameter int LONG_LEN = 8
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // user side
    input wire logic enable,
    input wire logic [7:0] busy_cycles,
    input wire logic [31:0] store_word,
    output logic store_take,
    output logic [31:0] load_word,
    output logic load_strobe,
    output logic op_strobe,
    output logic [23:0] op_fields,
    // processor side
    cip_if.coproc_end cp
);
    typedef enum logic [3:0] {
        CS_IDLE = 4'h1,
        CS_BUSY = 4'h2,
        CS_READY = 4'h4,
        CS_XFER = 4'h8
    } cip_cp_state_t;

    if (SHORT_LEN < 1 || SHORT_LEN > 65535 || LONG_LEN < 1 || LONG_LEN > 65535)
    begin : g_len_check
        $error("transfer lengths out of range");
    end

    cip_cp_state_t state_reg;
    logic [7:0] wait_reg;
    logic [15:0] left_reg;
    logic mine;
    logic is_cdp;

    // number must match, else refuse
    assign mine = enable && (cp.instr[cip_pkg::CIP_BIT_NUM +: 4] == CP_NUM)
                  && ((cp.instr[27:24] == cip_pkg::CIP_CLASS_CDP
                       && !cp.instr[cip_pkg::CIP_BIT_OPTYPE])
                      || cp.instr[27:25] == cip_pkg::CIP_CLASS_XFER);
    assign is_cdp = cp.instr[25]; // data-op class has bit 25 set, transfers clear

    // handshake and transfer sequence; all state rebuilt from the instruction,
    // so a retried transfer after an abort repeats exactly
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= CS_IDLE;
            wait_reg <= 8'h00;
            left_reg <= 16'h0000;
            cp.absent <= 1'b1;
            cp.busy <= 1'b1;
            cp.store_data <= cip_pkg::CIP_RST_WORD;
            cp.last_word <= 1'b0;
            store_take <= 1'b0;
            op_strobe <= 1'b0;
            op_fields <= 24'h000000;
        end
        else
        begin
            store_take <= 1'b0;
            op_strobe <= 1'b0;
            case (state_reg)
                CS_IDLE:
                begin
                    cp.absent <= 1'b1; // refuse by default
                    cp.busy <= 1'b1;
                    if (cp.offer && mine)
                    begin
                        cp.absent <= 1'b0;
                        cp.busy <= (busy_cycles != 8'h00);
                        wait_reg <= busy_cycles;
                        state_reg <= (busy_cycles != 8'h00) ? CS_BUSY : CS_READY;
                    end
                end
                CS_BUSY:
                begin
                    if (wait_reg == 8'h01)
                    begin
                        cp.busy <= 1'b0;
                        state_reg <= CS_READY;
                    end
                    wait_reg <= wait_reg - 8'h01;
                end
                CS_READY:
                begin
                    cp.absent <= 1'b1;
                    cp.busy <= 1'b1;
                    if (is_cdp)
                    begin
                        op_strobe <= 1'b1; // opcode/sources/dest to user
                        op_fields <= cp.instr[23:0];
                        state_reg <= CS_IDLE;
                    end
                    else
                    begin
                        // length bit picks one of two lengths
                        left_reg <= cp.instr[cip_pkg::CIP_BIT_LEN] ? LONG_LEN[15:0]
                                                                   : SHORT_LEN[15:0];
                        cp.last_word <= cp.instr[cip_pkg::CIP_BIT_LEN] ? (LONG_LEN == 1)
                                                                       : (SHORT_LEN == 1);
                        cp.store_data <= store_word;
                        store_take <= 1'b1;
                        state_reg <= CS_XFER;
                    end
                end
                CS_XFER:
                begin
                    if (cp.xfer_abort)
                        state_reg <= CS_IDLE;
                    else if (cp.word_strobe)
                    begin
                        if (left_reg == 16'h0001)
                            state_reg <= CS_IDLE;
                        else
                        begin
                            cp.store_data <= store_word;
                            store_take <= 1'b1;
                            cp.last_word <= (left_reg == 16'h0002);
                        end
                        left_reg <= left_reg - 16'h0001;
                    end
                end
                default: state_reg <= CS_IDLE;
            endcase
        end
    end

    // loaded words go straight to the user
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            load_word <= cip_pkg::CIP_RST_WORD;
            load_strobe <= 1'b0;
        end
        else
        begin
            // the last word arrives after the sequencer went idle, so no state gate
            load_strobe <= cp.load_valid;
            if (cp.load_valid)
                load_word <= cp.load_data;
        end
    end
endmodule : cip_coproc_end
`default_nettype wire

/* tb/cip_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ************
// wire rules
// ************
module cip_properties
#(parameter logic [3:0] CP_NUM = 4'h1)
(
    // clock, reset
    input wire logic mclk,
    input wire logic rstn,
    // handshake
    input wire logic offer,
    input wire logic [31:0] instr,
    input wire logic absent,
    input wire logic busy,
    // transfer
    input wire logic word_strobe,
    input wire logic load_valid,
    input wire logic xfer_abort
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // offer is ours: our number and a class we take
    logic mine;
    assign mine = instr[11:8] == CP_NUM && (instr[27:25] == cip_pkg::CIP_CLASS_XFER
        || instr[27:24] == cip_pkg::CIP_CLASS_CDP && !instr[4]);
    a_mine_answers: assert property ($rose(offer) && mine |-> ##[1:2] !absent)
        else $error("no answer");
    a_other_ignored: assert property ($rose(offer) && !mine |-> ##1 (absent && busy)[*2])
        else $error("foreign offer answered");
    a_refuse_both: assert property (absent |-> busy)
        else $error("absent without busy");
    a_word_pulse: assert property (word_strobe |=> !word_strobe)
        else $error("word strobe too long");
    a_load_after: assert property (load_valid |-> $past(word_strobe))
        else $error("load data without word");
    a_abort_after: assert property (xfer_abort |-> $past(word_strobe))
        else $error("abort without word");
    a_instr_hold: assert property (offer |-> $stable(instr))
        else $error("instruction moved");
    a_offer_bound: assert property ($rose(offer) |-> ##[1:40] !offer)
        else $error("offer hangs");
endmodule : cip_properties
`default_nettype wire

/* tb/coprocessor_instruction_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module coprocessor_instruction_port_tb;
    logic mclk = 0, rstn = 0, cyc = 0, we = 0, abt = 0, ack, mreq;
    logic [7:0] adr = 0, bc = 0;
    logic [31:0] dw = 0, sw = 0, dro, ma, rd, ins, b, bv, m;
    logic [23:0] of;
    logic tu, ta, mwe, ls, stk;
    logic [31:0] mwd, lw, sw_d = 0;
    logic [31:0] lq[$], sq[$];
    int n_undef = 0, n_abort = 0;
    int n_fail = 0, comparisons = 0, seed = 27069, k;
    logic [31:0] q[$];
    cip_if cif();
    cip_core_end cip_core_end_i(.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dro),
        .wb_ack_o(ack), .mem_req(mreq), .mem_we(mwe), .mem_addr(ma), .mem_wdata(mwd),
        .mem_rdata(~ma), .mem_abort(abt & mreq), .trap_undef(tu), .trap_abort(ta), .cp(cif));
    cip_coproc_end #(.LONG_LEN(3)) cip_coproc_end_i(.mclk(mclk), .rstn(rstn), .enable(1'b1),
        .busy_cycles(bc), .store_word(sw), .store_take(stk), .load_word(lw), .load_strobe(ls),
        .op_strobe(), .op_fields(of), .cp(cif));
    cip_properties cip_properties_i(.mclk(mclk), .rstn(rstn), .offer(cif.offer),
        .instr(cif.instr), .absent(cif.absent), .busy(cif.busy), .word_strobe(cif.word_strobe),
        .load_valid(cif.load_valid), .xfer_abort(cif.xfer_abort));
    initial forever #25 mclk = ~mclk;
    // store data changes every cycle so a stale word shows
    // sw_d holds the word the coprocessor captured one edge before store_take shows
    always @(posedge mclk)
    begin
        if (stk === 1'b1 && ins[20] === 1'b0)
            sq.push_back(sw_d);
        sw_d <= sw;
        sw <= $random(seed);
    end
    // every memory word takes the oldest noted address, a store also the oldest store word; each load strobe takes the oldest load word
    always @(posedge mclk)
    begin
        if (mreq === 1'b1)
        begin
            chk(ma, q.pop_front());
            chk({31'h0, mwe}, {31'h0, !ins[20]});
            if (mwe === 1'b1)
                chk(mwd, sq.pop_front());
        end
        if (ls === 1'b1)
            chk(lw, lq.pop_front());
        if (tu === 1'b1)
            n_undef++;
        if (ta === 1'b1)
            n_abort++;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // one classic cycle, held until ack
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1;
        we <= w;
        adr <= a;
        dw <= d;
        k = 0;
        do @(posedge mclk); while (ack !== 1'b1 && ++k < 50);
        rd = dro;
        cyc <= 0;
        if (k >= 50)
        begin
            n_fail++;
            finish_test();
        end
        @(posedge mclk);
    endtask : wb
    // start an instruction, poll until idle, check status
    task run(input logic [31:0] i, input logic [31:0] st);
        int j;
        wb(1, 8'h00, i);
        j = 0;
        do wb(0, 8'h10, 0); while (rd[0] !== 1'b0 && ++j < 100);
        if (j >= 100)
        begin
            n_fail++;
            finish_test();
        end
        chk(rd, st);
    endtask : run
    task finish_test;
        $display("fails %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (3) @(posedge mclk);
        rstn <= 1;
        @(posedge mclk);
        // random transfers; pass 6 aborts, pass 7 uses the pc base
        for (int t = 0; t < 8; t++)
        begin
            ins = $random(seed);
            b = $random(seed);
            bc <= {5'h0, 3'($random(seed))};
            abt <= t == 6;
            ins[31:25] = 7'h76;
            ins[19:16] = t == 7 ? 4'hF : 4'h1;
            ins[11:8] = 4'h1;
            ins[22] = ins[22] && t != 6;
            ins[21] = ins[21] && t != 7;
            wb(1, 8'h04, b);
            wb(1, 8'h08, b);
            bv = t == 7 ? b + 32'h8 : b;
            m = ins[23] ? bv + {ins[7:0], 2'h0} : bv - {ins[7:0], 2'h0};
            for (int w = 0; w < (ins[22] ? 3 : 1); w++)
            begin
                q.push_back((ins[24] ? m : bv) + 32'(4 * w));
                if (ins[20] && t != 6)
                    lq.push_back(~((ins[24] ? m : bv) + 32'(4 * w)));
            end
            run(ins, {26'h0, ins[21], t == 6, 4'h2});
            wb(0, 8'h04, 0);
            chk(rd, ins[21] ? m : b);
        end
        abt <= 0;
        ins = $random(seed);
        ins[31:24] = 8'h0E;
        ins[11:8] = 4'h1;
        ins[4] = 0;
        run(ins, 32'h6);
        wb(1, 8'h0C, 32'h4);
        run(ins, 32'h2);
        chk({8'h0, of}, {8'h0, ins[23:0]});
        wb(0, 8'h18, 0);
        chk({16'h0, rd[31:16]}, {24'h0, bc});
        ins[11:8] = 4'h2;
        run(ins, 32'hA);
        wb(0, 8'h40, 0);
        chk(rd, 0);
        chk(32'(q.size()), 0);
        chk(32'(lq.size() + sq.size()), 0);
        chk(32'(n_undef), 1);
        chk(32'(n_abort), 1);
        finish_test();
    end
    // hang guard
    initial
    begin
        #2000000;
        n_fail++;
        finish_test();
    end
endmodule : coprocessor_instruction_port_tb
`default_nettype wire
